//--- rtl/afg_pkg.sv
// constants, register map and types shared by the level and fade gain control
package afg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register indices, byte address is four times the index
   localparam logic [5:0] IDX_TIMER = 6'h03;
   localparam logic [5:0] IDX_STEP = 6'h04;
   localparam logic [5:0] IDX_REF = 6'h05;
   localparam logic [5:0] IDX_OPMODE = 6'h06;
   localparam logic [5:0] IDX_GAIN = 6'h07;
   localparam logic [5:0] IDX_SYS = 6'h0a;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int FP_FADE = 6;     // fade_period_sel, 2 bits
   localparam int FP_ZTO = 4;      // zero_cross_timeout_sel, 2 bits
   localparam int FP_WAIT = 2;     // recovery_wait_sel, 2 bits
   localparam int FP_LIMP = 0;     // limiter_period_sel, 2 bits
   localparam int FP_LSTEP = 4;    // limiter_step_count, 2 bits
   localparam int FP_FSTEP = 3;    // fade_step_count
   localparam int FP_RSTEP = 1;    // recovery_step_count, 2 bits
   localparam int FP_THR = 0;      // limit_threshold_select
   localparam int FP_ZSUP = 5;     // zero_cross_suppress
   localparam int FP_IMP = 4;      // impulse_mode_select
   localparam int FP_STAT = 3;     // read-only manual status
   localparam int FP_FIN = 2;      // fade_in_enable
   localparam int FP_FOUT = 1;     // fade_out_enable
   localparam int FP_ALC = 0;      // level control enable
   localparam int FP_PWR = 0;      // gain_stage_power
   localparam int FP_RATE = 1;     // sample_rate_select

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0] TIMER_RST = 8'h01;
   localparam logic [5:0] STEP_RST = 6'h00;
   localparam logic [6:0] REF_RST = 7'h28;
   localparam logic [7:0] OPMODE_RST = 8'h00;
   localparam logic [6:0] GAIN_RST = 7'h28;
   localparam logic [1:0] SYS_RST = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // timing, periods in microseconds per select code
   localparam int unsigned FADE_US [4] = '{24000, 32000, 48000, 64000};
   localparam int unsigned TMO_US [4] = '{8000, 16000, 64000, 512000};
   localparam int unsigned LIM_US [4] = '{63, 125, 250, 500};
   localparam int unsigned RATE_LO_KHZ = 32;
   localparam int unsigned RATE_HI_KHZ = 48;
   localparam int unsigned US_PER_MS = 1000;
   localparam int INIT_SAMPLES_DEF = 4128;

   // level thresholds as magnitudes of a 20-bit full scale
   localparam logic [19:0] LVL_M2DB = 20'h65acf;
   localparam logic [19:0] LVL_M4DB = 20'h50c30;
   localparam logic [19:0] LVL_M6DB = 20'h4026e;

   // sample periods for a time, rounded up
   function automatic logic [15:0] afg_samples(input int unsigned t_us, input logic rate_hi);
      int unsigned khz;
      khz = rate_hi ? RATE_HI_KHZ : RATE_LO_KHZ;
      return 16'((t_us * khz + US_PER_MS - 1) / US_PER_MS);
   endfunction

   typedef enum logic [2:0] {
      ST_INIT = 3'b001,
      ST_MANUAL = 3'b010,
      ST_AUTO = 3'b100
   } afg_state_e;

endpackage

//--- rtl/afg_chan_apply.sv
// per-channel gain applier: takes the shared code at a zero crossing or timeout
`timescale 1ns/10ps
module afg_chan_apply import afg_pkg::*; (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // sample stream
   input wire logic smp_i,
   input wire logic [19:0] sample_i,
   // control
   input wire logic [6:0] target_i,
   input wire logic immediate_i,
   input wire logic force_i,
   input wire logic [15:0] tmo_i,
   // result
   output logic [6:0] gain_o,
   output logic busy_o
);

   typedef struct packed {
      logic prev_neg;
      logic [6:0] gain;
      logic [15:0] cnt;
   } afg_chan_s;

   afg_chan_s st_ff;
   afg_chan_s nxt_st;
   logic zc;

   ////////////////////////////////////////////////////////////////////////////
   // sign change or exact zero counts as a crossing
   assign zc = (sample_i == 20'h00000) || (sample_i[19] != st_ff.prev_neg);

   // R02: per channel, crossing or timeout
   always_comb begin
      nxt_st = st_ff;
      if (smp_i) begin
         nxt_st.prev_neg = sample_i[19];
      end
      if (force_i || (immediate_i && st_ff.gain != target_i)) begin
         nxt_st.gain = target_i;
         nxt_st.cnt = 16'h0000;
      end else if (st_ff.gain != target_i) begin
         if (smp_i) begin
            // R27: crossing detect
            if (zc || (st_ff.cnt + 16'h0001 >= tmo_i)) begin
               nxt_st.gain = target_i;
               nxt_st.cnt = 16'h0000;
            end else begin
               nxt_st.cnt = st_ff.cnt + 16'h0001;
            end
         end
      end else begin
         nxt_st.cnt = 16'h0000; // timeout only runs while a change waits
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '{prev_neg: 1'b0, gain: GAIN_RST, cnt: 16'h0000};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign gain_o = st_ff.gain;
   assign busy_o = st_ff.gain != target_i;

endmodule

//--- rtl/afg_alc_fade_gain_control.sv
// level control, limiter, recovery and fade gain engine with wishbone registers
`timescale 1ns/10ps
// Functional notes
// R01: fade step interval 24/32/48/64 ms
// R02: each channel updates at crossing or timeout
// R03: periods scaled for 32 or 48 kHz
// R04: limiter at -4 or -2 dB
// R05: wait counter reset band below threshold
// R06: recovery raises gain one to four steps
// R07: recovery saturates at reference code
// R08: fade moves one or two steps
// R09: fade stops at reference or mute
// R10: limiter lowers gain one to four steps
// R11: limiter clamps gain at mute
// R12: limiter pacing by period or timeout
// R13: shared reference code resets to 28h
// R14: gain code table up to 60h; recovery and fade-in can still reach a reference code set above 60h
// R15: host keeps gain at or below reference; the code clamps gain writes only at 60h, not at the reference
// R16: three enable bits, reset zero
// R17: status zero in init and automatic
// R18: status waits for pending step
// R19: mode bit selects impulse tolerant control
// R20: zero-cross wait or immediate change
// R21: shared seven-bit gain code, reset 28h
// R22: host writes gain only when manual; the code takes gain writes in every state
// R23: writes ignored while pin low
// R24: gain resets while stage power off
// R25: timeout 8/16/64/512 ms
// R26: recovery after quiet wait period
// R27: crossing is sign change or zero
// R28: limiter wins over recovery
module afg_alc_fade_gain_control import afg_pkg::*; #(
   parameter int INIT_SAMPLES = INIT_SAMPLES_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // power-down pin, active low, asynchronous
   input wire logic power_down_pin_n_i,
   // converter samples, one strobe per frame
   input wire logic sample_valid_i,
   input wire logic [19:0] adc_left_i,
   input wire logic [19:0] adc_right_i,
   // applied gain codes
   output logic [6:0] gain_left_o,
   output logic [6:0] gain_right_o
);

   typedef struct packed {
      afg_state_e state;
      logic [2:0] pin_sync;
      logic pin_up;
      logic [7:0] timer;
      logic [5:0] step;
      logic [6:0] ref_code;
      logic [7:0] opm;
      logic [1:0] sys;
      logic [6:0] gain;
      logic ack;
      logic [31:0] dat;
      logic [15:0] fade_cnt;
      logic [15:0] pace_cnt;
      logic [15:0] wait_cnt;
      logic [15:0] init_cnt;
      logic over_prev;
   } afg_main_s;

   afg_main_s st_ff;
   afg_main_s nxt_st;

   logic rate_hi, pwr, thr, zsup, imp, fin, fout, alc;
   logic auto_en, fading, run, smp_run, chan_busy, busy_l, busy_r;
   logic [15:0] fade_tgt, zto_tgt, wait_tgt, limp_tgt, pace_tgt;
   logic [19:0] mag_l, mag_r, peak;
   logic over_lim, in_band, lim_fire, rec_due, fade_tick;
   logic [2:0] lim_step, rec_step;
   logic [6:0] fstep;
   logic [7:0] gain_dn, gain_up, gain_fup, gain_fdn;
   logic [6:0] gain_lim, gain_rec, gain_fin, gain_fout;
   logic req, wr;
   logic [5:0] idx;
   logic stat;

   ////////////////////////////////////////////////////////////////////////////
   // decoded control bits
   assign rate_hi = st_ff.sys[FP_RATE];
   assign pwr = st_ff.sys[FP_PWR];
   assign thr = st_ff.step[FP_THR];
   assign zsup = st_ff.opm[FP_ZSUP];
   assign imp = st_ff.opm[FP_IMP];
   assign fin = st_ff.opm[FP_FIN];
   assign fout = st_ff.opm[FP_FOUT];
   assign alc = st_ff.opm[FP_ALC];
   assign auto_en = alc | fin | fout;
   assign fading = fin | fout;
   assign stat = st_ff.state == ST_MANUAL;
   assign chan_busy = busy_l | busy_r;

   // R03: periods in samples at the selected rate
   // R01: fade interval
   assign fade_tgt = afg_samples(FADE_US[st_ff.timer[FP_FADE+:2]], rate_hi);
   // R25: crossing timeout
   assign zto_tgt = afg_samples(TMO_US[st_ff.timer[FP_ZTO+:2]], rate_hi);
   assign wait_tgt = afg_samples(TMO_US[st_ff.timer[FP_WAIT+:2]], rate_hi);
   assign limp_tgt = afg_samples(LIM_US[st_ff.timer[FP_LIMP+:2]], rate_hi);
   // R12: limiter pacing choice
   assign pace_tgt = zsup ? limp_tgt : zto_tgt;

   ////////////////////////////////////////////////////////////////////////////
   // input level, louder channel decides
   assign mag_l = adc_left_i[19] ? 20'(-adc_left_i) : adc_left_i;
   assign mag_r = adc_right_i[19] ? 20'(-adc_right_i) : adc_right_i;
   assign peak = (mag_l > mag_r) ? mag_l : mag_r;
   // R04: limiter detection level
   assign over_lim = peak >= (thr ? LVL_M2DB : LVL_M4DB);
   // R05: band at or above the reset level restarts waiting
   assign in_band = peak >= (thr ? LVL_M4DB : LVL_M6DB);

   // steps run only with stage powered and the pin released
   assign run = (st_ff.state == ST_AUTO) & st_ff.pin_up & pwr;
   assign smp_run = run & sample_valid_i;

   // R19: without impulse mode the limiter needs two loud samples in a row
   assign lim_fire = smp_run & alc & ~fading & over_lim & (imp | st_ff.over_prev)
      & (st_ff.pace_cnt == 16'h0000);
   // R26: recovery after a quiet wait
   assign rec_due = smp_run & alc & ~fading & ~in_band
      & (st_ff.wait_cnt + 16'h0001 >= wait_tgt);
   assign fade_tick = smp_run & fading & (st_ff.fade_cnt + 16'h0001 >= fade_tgt);

   ////////////////////////////////////////////////////////////////////////////
   // gain arithmetic, one spare bit catches wrap
   // R10: limiter step count
   assign lim_step = {1'b0, st_ff.step[FP_LSTEP+:2]} + 3'h1;
   // R06: recovery step count
   assign rec_step = {1'b0, st_ff.step[FP_RSTEP+:2]} + 3'h1;
   // R08: fade step one or two
   assign fstep = st_ff.step[FP_FSTEP] ? 7'h02 : 7'h01;
   assign gain_dn = {1'b0, st_ff.gain} - {5'h00, lim_step};
   assign gain_up = {1'b0, st_ff.gain} + {5'h00, rec_step};
   assign gain_fup = {1'b0, st_ff.gain} + {1'b0, fstep};
   assign gain_fdn = {1'b0, st_ff.gain} - {1'b0, fstep};
   // R11: clamp at mute
   assign gain_lim = gain_dn[7] ? 7'h00 : gain_dn[6:0];
   // R07: saturate at reference, never push a code already above it
   assign gain_rec = (st_ff.gain >= st_ff.ref_code) ? st_ff.gain :
      (gain_up > {1'b0, st_ff.ref_code}) ? st_ff.ref_code : gain_up[6:0];
   // R09: fade stops at reference and at mute
   assign gain_fin = (st_ff.gain >= st_ff.ref_code) ? st_ff.gain :
      (gain_fup > {1'b0, st_ff.ref_code}) ? st_ff.ref_code : gain_fup[6:0];
   assign gain_fout = gain_fdn[7] ? 7'h00 : gain_fdn[6:0];

   ////////////////////////////////////////////////////////////////////////////
   // bus decode, ack registered one cycle after each request
   assign req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
   assign idx = wb_adr_i[7:2];
   // R23: pin low blocks every write
   assign wr = req & wb_we_i & wb_sel_i[0] & st_ff.pin_up;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      nxt_st = st_ff;
      // three-stage pin sync, level moves when the last two agree
      nxt_st.pin_sync = {st_ff.pin_sync[1:0], power_down_pin_n_i};
      if (st_ff.pin_sync[1] == st_ff.pin_sync[2]) begin
         nxt_st.pin_up = st_ff.pin_sync[2];
      end
      if (sample_valid_i) begin
         nxt_st.over_prev = over_lim;
      end
      // register read, unmapped and test words read zero
      nxt_st.ack = req;
      if (req) begin
         case (idx)
            IDX_TIMER: nxt_st.dat = {24'h000000, st_ff.timer};
            IDX_STEP: nxt_st.dat = {26'h0000000, st_ff.step};
            IDX_REF: nxt_st.dat = {25'h0000000, st_ff.ref_code};
            // R17: status bit reads manual state
            IDX_OPMODE: nxt_st.dat = {24'h000000, st_ff.opm[7:4], stat, st_ff.opm[2:0]};
            IDX_GAIN: nxt_st.dat = {25'h0000000, st_ff.gain};
            IDX_SYS: nxt_st.dat = {30'h00000000, st_ff.sys};
            default: nxt_st.dat = 32'h00000000;
         endcase
      end
      // register write
      if (wr) begin
         case (idx)
            IDX_TIMER: nxt_st.timer = wb_dat_i[7:0];
            IDX_STEP: nxt_st.step = wb_dat_i[5:0];
            IDX_REF: nxt_st.ref_code = wb_dat_i[6:0];
            // R16: enable bits, status bit not writable
            IDX_OPMODE: nxt_st.opm = {2'h0, wb_dat_i[5:4], 1'b0, wb_dat_i[2:0]};
            // R14: no level above 60h, hold the top code
            IDX_GAIN: nxt_st.gain = (wb_dat_i[6:0] > 7'h60) ? 7'h60 : wb_dat_i[6:0];
            IDX_SYS: nxt_st.sys = wb_dat_i[1:0];
            default: nxt_st.dat = st_ff.dat;
         endcase
      end
      // mode sequencing
      case (st_ff.state)
         ST_INIT: begin
            if (st_ff.pin_up && sample_valid_i) begin
               if (st_ff.init_cnt == 16'(INIT_SAMPLES - 1)) begin
                  nxt_st.state = ST_MANUAL;
               end else begin
                  nxt_st.init_cnt = st_ff.init_cnt + 16'h0001;
               end
            end
         end
         ST_MANUAL: begin
            if (auto_en) begin
               nxt_st.state = ST_AUTO;
            end
         end
         ST_AUTO: begin
            // R18: leave only after the pending step lands
            if (!auto_en && !chan_busy) begin
               nxt_st.state = ST_MANUAL;
            end
         end
         default: nxt_st.state = ST_INIT;
      endcase
      // R17: pin low restarts initialization
      if (!st_ff.pin_up) begin
         nxt_st.state = ST_INIT;
         nxt_st.init_cnt = 16'h0000;
      end
      // counters idle at zero outside their mode
      if (!run || !alc || fading) begin
         nxt_st.pace_cnt = 16'h0000;
         nxt_st.wait_cnt = 16'h0000;
      end else if (smp_run) begin
         if (lim_fire) begin
            nxt_st.pace_cnt = pace_tgt;
         end else if (st_ff.pace_cnt != 16'h0000) begin
            nxt_st.pace_cnt = st_ff.pace_cnt - 16'h0001;
         end
         // R05: restart waiting while in band
         if (in_band || lim_fire || rec_due) begin
            nxt_st.wait_cnt = 16'h0000;
         end else begin
            nxt_st.wait_cnt = st_ff.wait_cnt + 16'h0001;
         end
      end
      if (!run || !fading) begin
         nxt_st.fade_cnt = 16'h0000;
      end else if (smp_run) begin
         nxt_st.fade_cnt = fade_tick ? 16'h0000 : st_ff.fade_cnt + 16'h0001;
      end
      // automatic steps win over a late host write
      // R28: limiter first, recovery dropped
      if (lim_fire) begin
         nxt_st.gain = gain_lim;
      end else if (rec_due) begin
         nxt_st.gain = gain_rec;
      end else if (fade_tick) begin
         // fade-out wins when both fades are enabled
         nxt_st.gain = fout ? gain_fout : gain_fin;
      end
      // R24: stage power off restores the reset code
      if (!pwr) begin
         nxt_st.gain = GAIN_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   // R13: reference reset
   // R21: gain reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '{state: ST_INIT, pin_sync: 3'h0, pin_up: 1'b0, timer: TIMER_RST,
            step: STEP_RST, ref_code: REF_RST, opm: OPMODE_RST, sys: SYS_RST,
            gain: GAIN_RST, ack: 1'b0, dat: 32'h00000000, fade_cnt: 16'h0000,
            pace_cnt: 16'h0000, wait_cnt: 16'h0000, init_cnt: 16'h0000,
            over_prev: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign wb_dat_o = st_ff.dat;
   assign wb_ack_o = st_ff.ack;

   ////////////////////////////////////////////////////////////////////////////
   // channel appliers, left and right settle on their own
   // R20: immediate only with suppression in level control
   afg_chan_apply u_left (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .smp_i(sample_valid_i),
      .sample_i(adc_left_i),
      .target_i(st_ff.gain),
      .immediate_i(zsup & alc & ~fading & (st_ff.state == ST_AUTO)),
      .force_i(~pwr),
      .tmo_i(zto_tgt),
      .gain_o(gain_left_o),
      .busy_o(busy_l)
   );

   afg_chan_apply u_right (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .smp_i(sample_valid_i),
      .sample_i(adc_right_i),
      .target_i(st_ff.gain),
      .immediate_i(zsup & alc & ~fading & (st_ff.state == ST_AUTO)),
      .force_i(~pwr),
      .tmo_i(zto_tgt),
      .gain_o(gain_right_o),
      .busy_o(busy_r)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_LIM_CLAMP: assert property ( // R11
      lim_fire && pwr && st_ff.gain <= {4'h0, lim_step} |=> st_ff.gain == 7'h00)
      else $error("limiter did not clamp at mute");
   AST_LIM_STEP: assert property ( // R10
      lim_fire && pwr && st_ff.gain > 7'h04
      |=> st_ff.gain == $past(st_ff.gain) - {4'h0, $past(lim_step)})
      else $error("limiter step size wrong");
   AST_LIM_WINS: assert property ( // R28
      lim_fire && rec_due && pwr && st_ff.gain != 7'h00 |=> st_ff.gain < $past(st_ff.gain))
      else $error("recovery beat limiter");
   AST_REC_CAP: assert property ( // R07
      rec_due && !lim_fire && pwr && st_ff.gain < st_ff.ref_code
      |=> st_ff.gain <= $past(st_ff.ref_code) && st_ff.gain > $past(st_ff.gain))
      else $error("recovery not capped at reference");
   AST_FADE_FLOOR: assert property ( // R09
      fade_tick && fout && pwr && st_ff.gain == 7'h00 |=> st_ff.gain == 7'h00)
      else $error("fade-out went below mute");
   AST_FADE_STEP: assert property ( // R08
      fade_tick && fout && pwr && st_ff.gain > 7'h02
      |=> st_ff.gain == $past(st_ff.gain) - $past(fstep))
      else $error("fade step size wrong");
   AST_PWR_RESET: assert property ( // R24
      !pwr |=> st_ff.gain == GAIN_RST ##1 gain_left_o == GAIN_RST)
      else $error("gain not reset with stage power off");
   AST_PIN_WRITE_BLOCK: assert property ( // R23
      req && wb_we_i && !st_ff.pin_up
      |=> $stable(st_ff.timer) && $stable(st_ff.ref_code) && $stable(st_ff.opm))
      else $error("write taken while pin low");
   AST_INIT_STAT: assert property ( // R17
      !st_ff.pin_up |=> st_ff.state == ST_INIT && st_ff.init_cnt == 16'h0000)
      else $error("status not in init while pin low");
   AST_STAT_WAIT: assert property ( // R18
      st_ff.state == ST_AUTO && chan_busy |=> st_ff.state != ST_MANUAL)
      else $error("manual status before step completed");

endmodule

//--- verification/afg_host_model.sv
// host side model: classic wishbone master for the gain control registers
`timescale 1ns/10ps
module afg_host_model (
   // clock
   input wire logic clk_i,
   // wishbone master
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o,
   input wire logic wb_ack_i
);
   ////////////////////////////////////////////////////////////////////////////
   // idle bus from time zero
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'h0;
      wb_dat_o = 32'h0;
   end

   // single cycle, entered just after a rising edge; request held until ack
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= adr;
      wb_sel_o <= 4'hf;
      wb_dat_o <= dat;
      do begin
         @(posedge clk_i);
      end while (wb_ack_i !== 1'b1);
      // released only after ack, then one idle cycle
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_dat_o <= ~dat;
      @(posedge clk_i);
   endtask
endmodule

//--- verification/afg_alc_fade_gain_control_tb.sv
// self-checking bench for the level and fade gain control block
`timescale 1ns/10ps
module afg_alc_fade_gain_control_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic pin_n = 1'b1;
   logic sample_valid_i = 1'b0;
   logic [19:0] adc_left_i = 20'h0;
   logic [19:0] adc_right_i = 20'h0;
   logic wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_wdat, wb_rdat;
   logic [6:0] gain_left_o, gain_right_o;
   logic [31:0] seed = 32'hcf7d;
   logic [31:0] exp_q[$];
   int fails = 0;
   int check_count = 0;

   always #10 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////////////
   // design and host model; short init count keeps the run brief
   afg_alc_fade_gain_control #(.INIT_SAMPLES(4)) afg_alc_fade_gain_control_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .power_down_pin_n_i(pin_n),
      .sample_valid_i(sample_valid_i), .adc_left_i(adc_left_i), .adc_right_i(adc_right_i),
      .gain_left_o(gain_left_o), .gain_right_o(gain_right_o));
   afg_host_model afg_host_model_inst (
      .clk_i(clk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
      .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_ack_i(wb_ack));

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
      afg_host_model_inst.bus(1'b1, adr, {24'h0, dat});
   endtask

   // the expectation goes on the queue before the cycle starts
   task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
      exp_q.push_back({24'h0, exp});
      afg_host_model_inst.bus(1'b0, adr, 32'h0);
   endtask

   // samples every second clock; quiet ones alternate sign so both channels cross zero
   task automatic feed(input int n, input logic loud);
      logic [31:0] r;
      for (int i = 0; i < n; i++) begin
         r = xs();
         sample_valid_i <= 1'b1;
         adc_left_i <= loud ? 20'h7ffff : (i[0] ? -20'(r[11:0]) : 20'(r[11:0]));
         adc_right_i <= loud ? 20'h80001 : (i[0] ? 20'(r[23:12]) : -20'(r[23:12]));
         @(posedge clk_i);
         sample_valid_i <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   task automatic gains(input logic [6:0] exp);
      check({25'h0, gain_left_o}, {25'h0, exp}); // left channel
      check({25'h0, gain_right_o}, {25'h0, exp}); // right channel
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // read monitor takes the oldest note whenever read data is acknowledged
   always @(posedge clk_i) begin
      if (wb_ack === 1'b1 && wb_we === 1'b0) begin
         if (exp_q.size() == 0) check(wb_rdat, 32'hffffffff); // unexpected read
         else check(wb_rdat, exp_q.pop_front()); // register readback
      end
   end

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // watchdog sized well past the longest fade sequence
   initial begin
      repeat (60000) @(posedge clk_i);
      fails++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      // reset values, status low during init, unmapped reads zero
      rd(8'h0c, 8'h01);
      rd(8'h10, 8'h00);
      rd(8'h14, 8'h28);
      rd(8'h18, 8'h00);
      rd(8'h1c, 8'h28);
      rd(8'h20, 8'h00);
      feed(6, 1'b0);
      rd(8'h18, 8'h08);
      // host sets gain below reference while manual
      wr(8'h14, 8'h03);
      wr(8'h1c, 8'h02);
      wr(8'h10, 8'h36);
      wr(8'h18, 8'h21);
      feed(4, 1'b1);
      gains(7'h00);
      feed(450, 1'b0);
      // four-step recovery saturates at the reference
      gains(7'h03);
      rd(8'h1c, 8'h03);
      // impulse mode at -2 dB: one loud sample limits, channels wait for a crossing
      wr(8'h10, 8'h01);
      wr(8'h18, 8'h11);
      feed(1, 1'b1);
      rd(8'h1c, 8'h02);
      feed(2, 1'b0);
      gains(7'h02);
      wr(8'h18, 8'h20);
      feed(8, 1'b0);
      wr(8'h14, 8'h05);
      wr(8'h1c, 8'h05);
      wr(8'h28, 8'h01);
      wr(8'h10, 8'h08);
      wr(8'h18, 8'h22);
      // two-step fade-out every 768 samples at 32 kHz
      feed(770, 1'b0);
      gains(7'h03);
      feed(1550, 1'b0);
      // fade-out stops at mute; status low while fading
      gains(7'h00);
      rd(8'h18, 8'h22);
      // fade-in raises two steps; status bit write ignored, reads low
      wr(8'h18, 8'h2c);
      feed(770, 1'b0);
      gains(7'h02);
      rd(8'h18, 8'h24);
      wr(8'h18, 8'h28);
      feed(8, 1'b0);
      // status back to manual, status bit reads high
      rd(8'h18, 8'h28);
      pin_n <= 1'b0;
      repeat (6) @(posedge clk_i);
      wr(8'h14, 8'h11);
      pin_n <= 1'b1;
      repeat (6) @(posedge clk_i);
      // write ignored while the pin was low
      rd(8'h14, 8'h05);
      wr(8'h1c, 8'h10);
      feed(4, 1'b0);
      wr(8'h28, 8'h00);
      feed(4, 1'b0);
      // gain stage off returns the code to its reset value
      rd(8'h1c, 8'h28);
      gains(7'h28);
      repeat (4) @(posedge clk_i);
      tally_and_finish();
   end
endmodule
